// ### src/break_unit_cfg.svh
// break_condition_unit constants: register offsets, field positions, reset values
// assumes inclusion by bare name from design files under src/
`ifndef BREAK_UNIT_CFG_SVH
`define BREAK_UNIT_CFG_SVH
`define OFS_ADDR_UPPER 12'h000
`define OFS_ADDR_LOWER 12'h004
`define OFS_MASK_UPPER 12'h008
`define OFS_MASK_LOWER 12'h00C
`define OFS_QUALIFIER 12'h010
`define OFS_MATCH_STATUS 12'h014
`define REG_RESET 16'h0000
`define QUAL_WMASK 16'h00FF
`define QUAL_MASTER_HI 7
`define QUAL_MASTER_LO 6
`define QUAL_ACCESS_HI 5
`define QUAL_ACCESS_LO 4
`define QUAL_DIR_HI 3
`define QUAL_DIR_LO 2
`define QUAL_SIZE_HI 1
`define QUAL_SIZE_LO 0
`define BREAK_PRIORITY 4'hF
`endif

// ### src/break_unit_pkg.sv
// break_condition_unit types: operand size codes, bus slave states
// assumes nothing of its surroundings
package break_unit_pkg;
  typedef enum logic [1:0] {
    size_any = 2'b00,
    size_byte = 2'b01,
    size_word = 2'b10,
    size_long = 2'b11
  } size_t;
  typedef enum logic [1:0] {
    apb_idle = 2'b01,
    apb_access = 2'b10
  } apb_state_t;
endpackage

// ### src/break_cond_match.sv
// break_condition_unit cycle matcher: combinational compare of one bus cycle
// assumes all inputs are on pclk and stable while cycle_valid is high
`timescale 1ns/1ps
`default_nettype none
`include "break_unit_cfg.svh"
module break_cond_match
  import break_unit_pkg::*;
(
  input wire logic [31:0] cmp_addr,
  input wire logic [31:0] cmp_mask,
  input wire logic [7:0] qual,
  input wire logic cycle_valid,
  input wire logic [31:0] cycle_addr,
  input wire logic cycle_is_dma,
  input wire logic cycle_is_fetch,
  input wire logic cycle_is_write,
  input wire break_unit_pkg::size_t cycle_size,
  output logic hit
);
  wire logic addr_ok;
  wire logic master_ok;
  wire logic access_ok;
  wire logic dir_ok;
  wire logic size_ok;
  wire break_unit_pkg::size_t eff_size;
  wire break_unit_pkg::size_t sel_size;

  assign addr_ok = &(~(cycle_addr ^ cmp_addr) | cmp_mask);
  // a 00 master, access or direction field matches nothing, so no break can occur
  assign master_ok = cycle_is_dma ? qual[`QUAL_MASTER_HI] : qual[`QUAL_MASTER_LO];
  assign access_ok = cycle_is_fetch ? qual[`QUAL_ACCESS_LO] : qual[`QUAL_ACCESS_HI];
  assign dir_ok = cycle_is_write ? qual[`QUAL_DIR_HI] : qual[`QUAL_DIR_LO];
  assign eff_size = cycle_is_fetch ? size_word : cycle_size;
  assign sel_size = size_t'(qual[`QUAL_SIZE_HI:`QUAL_SIZE_LO]);
  assign size_ok = (sel_size == size_any) || (sel_size == eff_size);
  assign hit = cycle_valid && addr_ok && master_ok && access_ok && dir_ok && size_ok;
endmodule
`default_nettype wire

// ### src/break_condition_unit.sv
// break_condition_unit: apb register file and break request generation
// assumes cpu and dma cycle strobes come from logic on pclk, one pulse per cycle
`timescale 1ns/1ps
`default_nettype none
`include "break_unit_cfg.svh"
module break_condition_unit
  import break_unit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic cycle_valid,
  input wire logic [31:0] cycle_addr,
  input wire logic cycle_is_dma,
  input wire logic cycle_is_fetch,
  input wire logic cycle_is_write,
  input wire break_unit_pkg::size_t cycle_size,
  output logic break_req,
  output logic [3:0] break_level
);
  import break_unit_pkg::*;

  logic [15:0] addr_hi_q;
  logic [15:0] addr_lo_q;
  logic [15:0] mask_hi_q;
  logic [15:0] mask_lo_q;
  logic [15:0] qual_q;
  logic [31:0] prdata_q;
  logic break_q;
  logic hit_seen_q;
  apb_state_t state_q;
  apb_state_t state_d;
  wire logic hit;
  wire logic setup;
  wire logic wr_en;
  wire logic rd_en;
  wire logic sel_ah;
  wire logic sel_al;
  wire logic sel_mh;
  wire logic sel_ml;
  wire logic sel_qu;
  wire logic sel_st;
  wire logic mapped;
  wire logic [15:0] wr_lane;
  wire logic [31:0] rd_mux;

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  break_cond_match u_match (
    .cmp_addr({addr_hi_q, addr_lo_q}),
    .cmp_mask({mask_hi_q, mask_lo_q}),
    .qual(qual_q[7:0]),
    .cycle_valid(cycle_valid),
    .cycle_addr(cycle_addr),
    .cycle_is_dma(cycle_is_dma),
    .cycle_is_fetch(cycle_is_fetch),
    .cycle_is_write(cycle_is_write),
    .cycle_size(cycle_size),
    .hit(hit)
  );

  // apb decode
  assign setup = psel && !penable;
  assign sel_ah = (paddr == `OFS_ADDR_UPPER);
  assign sel_al = (paddr == `OFS_ADDR_LOWER);
  assign sel_mh = (paddr == `OFS_MASK_UPPER);
  assign sel_ml = (paddr == `OFS_MASK_LOWER);
  assign sel_qu = (paddr == `OFS_QUALIFIER);
  assign sel_st = (paddr == `OFS_MATCH_STATUS);
  assign mapped = sel_ah || sel_al || sel_mh || sel_ml || sel_qu || sel_st;
  assign wr_en = psel && penable && pwrite && mapped && (state_q == apb_access);
  assign rd_en = setup && !pwrite;
  assign pready = (state_q == apb_access);
  assign pslverr = pready && !mapped;
  assign wr_lane = merge16(16'h0000, pwdata, pstrb);

  // read data: reserved qualifier bits read zero
  assign rd_mux = sel_ah ? {16'h0000, addr_hi_q} :
                  sel_al ? {16'h0000, addr_lo_q} :
                  sel_mh ? {16'h0000, mask_hi_q} :
                  sel_ml ? {16'h0000, mask_lo_q} :
                  sel_qu ? {16'h0000, qual_q & `QUAL_WMASK} :
                  sel_st ? {31'h0000_0000, hit_seen_q} :
                  32'h0000_0000;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      apb_idle:
      begin
        if (setup)
          state_d = apb_access;
      end
      apb_access:
        state_d = apb_idle;
      default:
        state_d = apb_idle;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= apb_idle;
    else
      state_q <= state_d;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_q <= 32'h0000_0000;
    else if (rd_en)
      prdata_q <= rd_mux;
  end
  assign prdata = prdata_q;

  // no standby input: contents are only changed by reset or writes
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      addr_hi_q <= `REG_RESET;
      addr_lo_q <= `REG_RESET;
      mask_hi_q <= `REG_RESET;
      mask_lo_q <= `REG_RESET;
      qual_q <= `REG_RESET;
    end
    else if (wr_en)
    begin
      if (sel_ah)
        addr_hi_q <= merge16(addr_hi_q, pwdata, pstrb);
      if (sel_al)
        addr_lo_q <= merge16(addr_lo_q, pwdata, pstrb);
      if (sel_mh)
        mask_hi_q <= merge16(mask_hi_q, pwdata, pstrb);
      if (sel_ml)
        mask_lo_q <= merge16(mask_lo_q, pwdata, pstrb);
      if (sel_qu)
        qual_q <= merge16(qual_q, pwdata, pstrb) & `QUAL_WMASK;
    end
  end

  // one pulse per matching cycle; sticky status cleared by writing bit 0 as 1, hit wins
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      break_q <= 1'b0;
      hit_seen_q <= 1'b0;
    end
    else
    begin
      break_q <= hit;
      if (hit)
        hit_seen_q <= 1'b1;
      else if (wr_en && sel_st && wr_lane[0])
        hit_seen_q <= 1'b0;
    end
  end

  assign break_req = break_q;
  assign break_level = `BREAK_PRIORITY;

  // assertions
  AST_PULSE_FOLLOWS_HIT: assert property (@(posedge pclk) disable iff (!presetn)
    hit |=> break_req)
    else $error("break request missing after matching cycle");
  AST_NO_SPURIOUS: assert property (@(posedge pclk) disable iff (!presetn)
    break_req |-> $past(cycle_valid))
    else $error("break request without a bus cycle");
  AST_BLOCKED_MASTER: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[7:6] == 2'b00) |=> !break_req)
    else $error("break with master field zero");
  AST_BLOCKED_ACCESS: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[5:4] == 2'b00) |=> !break_req)
    else $error("break with access field zero");
  AST_CPU_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[7:6] == 2'b01 && cycle_is_dma) |=> !break_req)
    else $error("dma cycle broke in cpu only mode");
  AST_FETCH_WORD: assert property (@(posedge pclk) disable iff (!presetn)
    (cycle_valid && cycle_is_fetch && qual_q[1:0] == 2'b01) |=> !break_req)
    else $error("fetch matched byte size");
  AST_RESERVED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    qual_q[15:8] == 8'h00)
    else $error("reserved qualifier bits set");
  AST_WRITE_LANDS: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel_al && pstrb == 4'hF) |=> addr_lo_q == $past(pwdata[15:0]))
    else $error("lower address write lost");
  AST_READY_TIMING: assert property (@(posedge pclk) disable iff (!presetn)
    (setup ##1 (psel && penable)) |-> pready)
    else $error("access phase without ready");
  AST_LEVEL: assert property (@(posedge pclk) disable iff (!presetn)
    break_req |-> break_level == 4'hF)
    else $error("wrong break priority");
  AST_BLOCKED_DIR: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[3:2] == 2'b00) |=> !break_req)
    else $error("break with direction field zero");
  AST_DMA_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[7:6] == 2'b10 && cycle_valid && !cycle_is_dma) |=> !break_req)
    else $error("cpu cycle broke in dma only mode");
  AST_FETCH_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[5:4] == 2'b01 && cycle_valid && !cycle_is_fetch) |=> !break_req)
    else $error("data cycle broke in fetch only mode");
  AST_DATA_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[5:4] == 2'b10 && cycle_valid && cycle_is_fetch) |=> !break_req)
    else $error("fetch broke in data only mode");
  AST_READ_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[3:2] == 2'b01 && cycle_valid && cycle_is_write) |=> !break_req)
    else $error("write broke in read only mode");
  AST_WRITE_ONLY: assert property (@(posedge pclk) disable iff (!presetn)
    (qual_q[3:2] == 2'b10 && cycle_valid && !cycle_is_write) |=> !break_req)
    else $error("read broke in write only mode");
  AST_SIZE_MISMATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (cycle_valid && !cycle_is_fetch && qual_q[1:0] != 2'b00 && qual_q[1:0] != cycle_size) |=> !break_req)
    else $error("data cycle broke with wrong size");
  AST_ADDR_MISS: assert property (@(posedge pclk) disable iff (!presetn)
    (cycle_valid && (((cycle_addr ^ {addr_hi_q, addr_lo_q}) & ~{mask_hi_q, mask_lo_q}) != 32'h0000_0000))
    |=> !break_req)
    else $error("break on unmasked address mismatch");
  AST_FULL_MATCH: assert property (@(posedge pclk) disable iff (!presetn)
    (cycle_valid && (((cycle_addr ^ {addr_hi_q, addr_lo_q}) & ~{mask_hi_q, mask_lo_q}) == 32'h0000_0000)
    && qual_q[7:0] == 8'hFC) |=> break_req)
    else $error("matching cycle gave no break");
  AST_NO_PULSE_WITHOUT_HIT: assert property (@(posedge pclk) disable iff (!presetn)
    !hit |=> !break_req)
    else $error("break request without a match");
  AST_UPPER_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel_ah && pstrb == 4'hF) |=> addr_hi_q == $past(pwdata[15:0]))
    else $error("upper address write lost");
  AST_MASK_WRITE: assert property (@(posedge pclk) disable iff (!presetn)
    (wr_en && sel_ml && pstrb == 4'hF) |=> mask_lo_q == $past(pwdata[15:0]))
    else $error("lower mask write lost");
  AST_QUAL_READ_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
    (pready && sel_qu && !pwrite) |-> prdata[31:8] == 24'h00_0000)
    else $error("reserved qualifier bits read nonzero");
  AST_REG_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && pwrite) |=> $stable({addr_hi_q, addr_lo_q, mask_hi_q, mask_lo_q, qual_q}))
    else $error("break registers changed without a write");
  AST_READY_ONE: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("ready held past the access phase");
  AST_STATUS_SET: assert property (@(posedge pclk) disable iff (!presetn)
    hit |=> hit_seen_q)
    else $error("status not set by a match");
  COV_FETCH_BREAK: cover property (@(posedge pclk) disable iff (!presetn)
    hit && cycle_is_fetch ##1 break_req);
  COV_STATUS_CLEAR: cover property (@(posedge pclk) disable iff (!presetn)
    wr_en && sel_st ##1 !hit_seen_q);
  COV_CPU_BREAK: cover property (@(posedge pclk) disable iff (!presetn)
    hit && !cycle_is_dma ##1 break_req);
  COV_DMA_BREAK: cover property (@(posedge pclk) disable iff (!presetn)
    hit && cycle_is_dma ##1 break_req);
  COV_MASKED_HIT: cover property (@(posedge pclk) disable iff (!presetn)
    hit && (mask_lo_q != 16'h0000));
endmodule
`default_nettype wire

// ### testbench/bus_cycle_model.sv
// far side model: cpu and dma bus cycle source, interrupt controller pending count
// assumes the block samples cycle fields on the rising pclk edge
`timescale 1ns/1ps
`default_nettype none
module bus_cycle_model
  import break_unit_pkg::*;
(
  input wire logic pclk,
  input wire logic break_req,
  output logic cyc_valid,
  output logic [31:0] cyc_addr,
  output logic cyc_dma,
  output logic cyc_fetch,
  output logic cyc_write,
  output break_unit_pkg::size_t cyc_size
);
  import break_unit_pkg::*;
  int pend_cnt = 0;
  initial
  begin
    cyc_valid = 1'b0;
    cyc_addr = 32'h0000_0000;
    cyc_dma = 1'b0;
    cyc_fetch = 1'b0;
    cyc_write = 1'b0;
    cyc_size = size_word;
  end
  // each pulse is held pending as one request
  always @(posedge pclk)
  begin
    if (break_req === 1'b1)
      pend_cnt <= pend_cnt + 1;
  end
  task automatic send(input logic [31:0] a, input logic d, input logic f, input logic w, input size_t s);
    @(posedge pclk);
    cyc_valid <= 1'b1;
    cyc_addr <= a;
    cyc_dma <= d;
    cyc_fetch <= f;
    cyc_write <= w;
    cyc_size <= s;
  endtask
  // released address and write fields stop showing the last cycle
  task automatic idle();
    @(posedge pclk);
    cyc_valid <= 1'b0;
    cyc_addr <= ~cyc_addr;
    cyc_write <= ~cyc_write;
  endtask
endmodule
`default_nettype wire

// ### testbench/tb.sv
// testbench for break_condition_unit: apb register checks and break matching
// assumes bus_cycle_model as far side and zero wait apb answers
`timescale 1ns/1ps
`default_nettype none
`include "break_unit_cfg.svh"
module tb;
  import break_unit_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h3;
  logic [31:0] prdata;
  logic pready, pslverr, break_req, cv, cd, cf, cw;
  logic [3:0] break_level;
  logic [31:0] ca;
  size_t cs;
  int error_cnt = 0;
  int check_count = 0;
  logic [11:0] ofs [5] = '{`OFS_ADDR_UPPER, `OFS_ADDR_LOWER, `OFS_MASK_UPPER, `OFS_MASK_LOWER, `OFS_QUALIFIER};
  break_condition_unit u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cycle_valid(cv), .cycle_addr(ca), .cycle_is_dma(cd), .cycle_is_fetch(cf), .cycle_is_write(cw),
    .cycle_size(cs), .break_req(break_req), .break_level(break_level));
  bus_cycle_model u_far (.pclk(pclk), .break_req(break_req), .cyc_valid(cv), .cyc_addr(ca), .cyc_dma(cd),
    .cyc_fetch(cf), .cyc_write(cw), .cyc_size(cs));
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, input logic e_err,
    input logic [31:0] e_rd);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 16);
    chk("pready", 32'h0000_0001, {31'h0, pready});
    chk("pslverr", {31'h0, e_err}, {31'h0, pslverr});
    if (!wr)
      chk("prdata", e_rd, prdata);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic fire(input logic [31:0] a, input logic d, input logic f, input logic w, input size_t s, input int e);
    int c0;
    c0 = u_far.pend_cnt;
    u_far.send(a, d, f, w, s);
    u_far.idle();
    repeat (3) @(posedge pclk);
    chk("break pulses", e, u_far.pend_cnt - c0);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 5; i++)
      apb(1'b0, ofs[i], 32'h0, 1'b0, 32'h0000_0000);
    apb(1'b0, 12'h020, 32'h0, 1'b1, 32'h0000_0000);
    chk("break_level", 32'h0000_000F, {28'h0, break_level});
    $display("done t_reset");
  endtask
  task automatic t_regs();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, ofs[i], 32'hFFFF_A5C3 ^ i, 1'b0, 32'h0);
      apb(1'b0, ofs[i], 32'h0, 1'b0, 32'h0000_A5C3 ^ i);
    end
    apb(1'b1, `OFS_QUALIFIER, 32'h0000_00FF, 1'b0, 32'h0);
    apb(1'b0, `OFS_QUALIFIER, 32'h0, 1'b0, 32'h0000_00FF);
    apb(1'b1, 12'h020, 32'h0000_1234, 1'b1, 32'h0);
    $display("done t_regs");
  endtask
  task automatic t_addr();
    apb(1'b1, `OFS_ADDR_UPPER, 32'h0000_0012, 1'b0, 32'h0);
    apb(1'b1, `OFS_ADDR_LOWER, 32'h0000_3456, 1'b0, 32'h0);
    apb(1'b1, `OFS_MASK_UPPER, 32'h0000_0000, 1'b0, 32'h0);
    apb(1'b1, `OFS_MASK_LOWER, 32'h0000_000F, 1'b0, 32'h0);
    apb(1'b1, `OFS_QUALIFIER, 32'h0000_006A, 1'b0, 32'h0);
    fire(32'h0012_345A, 1'b0, 1'b0, 1'b1, size_word, 1);
    fire(32'h0013_3456, 1'b0, 1'b0, 1'b1, size_word, 0);
    fire(32'h0012_3456, 1'b1, 1'b0, 1'b1, size_word, 0);
    apb(1'b1, `OFS_MASK_UPPER, 32'h0000_8000, 1'b0, 32'h0);
    fire(32'h8012_3450, 1'b0, 1'b0, 1'b1, size_word, 1);
    u_far.send(32'h0012_3451, 1'b0, 1'b0, 1'b1, size_word);
    fire(32'h0012_3452, 1'b0, 1'b0, 1'b1, size_word, 2);
    $display("done t_addr");
  endtask
  task automatic t_fields();
    apb(1'b1, `OFS_MASK_UPPER, 32'h0000_FFFF, 1'b0, 32'h0);
    apb(1'b1, `OFS_MASK_LOWER, 32'h0000_FFFF, 1'b0, 32'h0);
    for (int f = 0; f < 3; f++)
      for (int c = 0; c < 4; c++)
      begin
        apb(1'b1, `OFS_QUALIFIER, (32'hFC & ~(32'h3 << (6 - 2 * f))) | (c << (6 - 2 * f)), 1'b0, 32'h0);
        for (int b = 0; b < 2; b++)
          fire(32'h0000_0100, f == 0 && b == 1, f == 1 && b == 0, f == 2 && b == 1, size_word, c[b]);
      end
    $display("done t_fields");
  endtask
  task automatic t_size();
    for (int s = 0; s < 4; s++)
    begin
      apb(1'b1, `OFS_QUALIFIER, 32'hFC | s, 1'b0, 32'h0);
      for (int z = 1; z < 4; z++)
        fire(32'h0000_0200, 1'b0, 1'b0, 1'b0, size_t'(z), s == 0 || s == z);
      if (s % 2 == 0)
        fire(32'h0000_0200, 1'b0, 1'b1, 1'b0, size_long, 1);
    end
    $display("done t_size");
  endtask
  task automatic t_status();
    apb(1'b0, `OFS_MATCH_STATUS, 32'h0, 1'b0, 32'h0000_0001);
    apb(1'b1, `OFS_MATCH_STATUS, 32'h0000_0001, 1'b0, 32'h0);
    apb(1'b0, `OFS_MATCH_STATUS, 32'h0, 1'b0, 32'h0000_0000);
    apb(1'b1, `OFS_ADDR_LOWER, 32'h0000_BEEF, 1'b0, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 5; i++)
      apb(1'b0, ofs[i], 32'h0, 1'b0, 32'h0000_0000);
    fire(32'h0000_0000, 1'b0, 1'b0, 1'b0, size_word, 0);
    $display("done t_status");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    #100000;
    error_cnt++;
    end_of_test();
  end
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_regs();
    t_addr();
    t_fields();
    t_size();
    t_status();
    end_of_test();
  end
endmodule
`default_nettype wire
